//--- core/mss_sequencer.sv
// start-up sequencer with soft start, phase detection and phase clocking
// assumes command writes come from an external serial-bus engine, one per
// strobe, and that pin levels are synchronous to clock
`timescale 1ns/1ps
module mss_sequencer
  import mss_pkg::*;
#(
  parameter int unsigned CYC_MS   = CYC_PER_MS,   // cycles per millisecond
  parameter int unsigned MASK_CYC = PG_MASK_CYC   // power-good masking cycles
) (
  input  wire logic                   clock,        // 20 MHz master clock
  input  wire logic                   rst_n,        // sync reset, active low
  input  wire logic                   ce,           // clock enable
  input  wire logic                   enable,       // regulator enable
  input  wire logic                   supplyLockout, // supply below lockout
  input  wire logic [7:0]             voltageCodeIn, // target code, 6.25 mV units
  input  wire logic                   vcodeChange,  // on-the-fly code change
  input  wire logic [MAX_PHASES-1:0]  pwmReq,       // per-phase modulator demand
  input  wire logic [MAX_PHASES-1:0]  phaseIn,      // pin level above 3 V
  input  wire logic                   cmdWr,        // command write strobe
  input  wire logic [7:0]             cmdCode,      // command code
  input  wire logic [7:0]             cmdWrData,    // command write data
  input  wire logic                   cmdRd,        // command read strobe
  output logic      [7:0]             cmdRdData,    // command read data
  output logic      [MAX_PHASES-1:0]  phaseOut,     // phase output level
  output logic      [MAX_PHASES-1:0]  phaseOe,      // phase output enable
  output logic      [MAX_PHASES-1:0]  phaseTick,    // per-phase cycle start
  output logic      [REF_W-1:0]       refCode,      // reference, 6.25 mV units
  output logic                        powerGood,    // power good
  output logic      [8:0]             seqState,     // sequencer state
  output logic      [PH_CNT_W-1:0]    phaseCount    // active phase count
);

  // ************************************************************
  // declarations
  // ************************************************************
  mss_state_e            state_ff;
  mss_state_e            nxt_state;
  logic [7:0]            ssRate_ff;
  logic [7:0]            delayCfg_ff;
  logic [7:0]            cmdRdData_ff;
  logic [31:0]           msCnt_ff;
  logic [7:0]            msDone_ff;
  logic [31:0]           cycCnt_ff;
  logic [31:0]           slewAcc_ff;
  logic [REF_W-1:0]      refCode_ff;
  logic [REF_W-1:0]      target_ff;
  logic [MAX_PHASES-1:0] phaseOut_ff;
  logic [MAX_PHASES-1:0] phaseOe_ff;
  logic [MAX_PHASES-1:0] phaseTick_ff;
  logic [PH_CNT_W-1:0]   tickIdx_ff;
  logic                  powerGood_ff;
  logic [MAX_PHASES-1:0] activeMask;
  logic [PH_CNT_W-1:0]   detCount;
  logic                  runOk;
  logic                  delayDone;
  logic                  stepTick;
  logic                  stageEntry;
  logic                  timedStage;
  logic                  rampStage;
  logic                  atTarget;
  logic [REF_W-1:0]      rampGoal;
  logic [4:0]            rateTenths;
  logic [31:0]           stepRate;
  logic [2:0]            rateCode;

  assign runOk      = enable && !supplyLockout;
  assign timedStage = (state_ff == ST_DELAY) || (state_ff == ST_HOLD) ||
                      (state_ff == ST_BLANK);
  assign rampStage  = (state_ff == ST_RAMPBOOT) || (state_ff == ST_RAMPTGT);
  assign rampGoal   = (state_ff == ST_RAMPBOOT) ? BOOT_STEPS : target_ff;
  assign atTarget   = (refCode_ff == rampGoal);
  assign stageEntry = (nxt_state != state_ff);

  // ************************************************************
  // command registers
  // ************************************************************
  // rise-time and delay command fields
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ssRate_ff   <= SS_RATE_RST;
      delayCfg_ff <= DELAY_RST;
    end else if (ce && cmdWr) begin
      if (cmdCode == CMD_SS_RATE) begin
        ssRate_ff <= cmdWrData;
      end
      if (cmdCode == CMD_DELAY_CFG) begin
        delayCfg_ff <= cmdWrData;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmdRdData_ff <= RD_UNMAPPED;
    end else if (ce && cmdRd) begin
      case (cmdCode)
        CMD_SS_RATE:   cmdRdData_ff <= ssRate_ff;
        CMD_DELAY_CFG: cmdRdData_ff <= delayCfg_ff;
        CMD_STATUS:    cmdRdData_ff <= {powerGood_ff, 4'h0, detCount};
        default:       cmdRdData_ff <= RD_UNMAPPED;
      endcase
    end
  end

  // ************************************************************
  // stage timer: whole milliseconds of the delay setting
  // ************************************************************
  assign delayDone = (msDone_ff >= delayCfg_ff);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      msCnt_ff  <= '0;
      msDone_ff <= '0;
    end else if (ce) begin
      if (!timedStage || stageEntry) begin
        msCnt_ff  <= '0;
        msDone_ff <= '0;
      end else if (msCnt_ff == CYC_MS - 1) begin
        msCnt_ff  <= '0;
        msDone_ff <= msDone_ff + 8'h1;
      end else begin
        msCnt_ff <= msCnt_ff + 32'h1;
      end
    end
  end

  // cycle counter for detection and masking
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cycCnt_ff <= '0;
    end else if (ce) begin
      if (stageEntry || vcodeChange) begin
        cycCnt_ff <= '0;
      end else begin
        cycCnt_ff <= cycCnt_ff + 32'h1;
      end
    end
  end

  // ************************************************************
  // slew rate: accumulate steps per millisecond, step on overflow
  // ************************************************************
  // slew code decode, tenths of V/ms
  assign rateCode   = ssRate_ff[SS_RATE_MSB:SS_RATE_LSB];
  assign rateTenths = (rateCode <= SS_SLOW_CODE) ? SS_SLOW_TENTHS :
                      5'({rateCode, 1'b0} + 4'h1);
  assign stepRate   = 32'(rateTenths) * STEP_PER_TENTH;
  assign stepTick   = (slewAcc_ff + stepRate >= CYC_MS);

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      slewAcc_ff <= '0;
    end else if (ce) begin
      if (!rampStage || stageEntry) begin
        slewAcc_ff <= '0;
      end else if (stepTick) begin
        slewAcc_ff <= slewAcc_ff + stepRate - CYC_MS;
      end else begin
        slewAcc_ff <= slewAcc_ff + stepRate;
      end
    end
  end

  // reference stepped one 6.25 mV unit at a time
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      refCode_ff <= '0;
    end else if (ce) begin
      if (state_ff == ST_IDLE) begin
        refCode_ff <= '0;
      end else if (rampStage && stepTick && !atTarget) begin
        // step up or down toward target
        if (refCode_ff < rampGoal) begin
          refCode_ff <= refCode_ff + REF_W'(1);
        end else begin
          refCode_ff <= refCode_ff - REF_W'(1);
        end
      end
    end
  end

  // sample voltage code at end of hold
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      target_ff <= '0;
    end else if (ce && state_ff == ST_HOLD && delayDone) begin
      target_ff <= REF_W'(voltageCodeIn);
    end
  end

  // ************************************************************
  // sequencer
  // ************************************************************
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:     if (runOk) nxt_state = ST_DELAY;
      ST_DELAY:    if (delayDone) nxt_state = ST_DETECT;
      ST_DETECT:   if (cycCnt_ff == DETECT_CYC - 1) nxt_state = ST_RAMPBOOT;
      ST_RAMPBOOT: if (atTarget) nxt_state = ST_HOLD;
      ST_HOLD:     if (delayDone) nxt_state = ST_RAMPTGT;
      ST_RAMPTGT:  if (atTarget) nxt_state = ST_MASK;
      ST_MASK:     if (cycCnt_ff >= MASK_CYC - 1) nxt_state = ST_BLANK;
      ST_BLANK:    if (delayDone) nxt_state = ST_GOOD;
      ST_GOOD:     if (vcodeChange) nxt_state = ST_MASK;
      default:     nxt_state = ST_IDLE;
    endcase
    if (!runOk) begin
      nxt_state = ST_IDLE;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state_ff <= ST_IDLE;
    end else if (ce) begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      powerGood_ff <= 1'b0;
    end else if (ce) begin
      powerGood_ff <= (nxt_state == ST_GOOD) ||
                      (powerGood_ff && nxt_state == ST_MASK);
    end
  end

  // ************************************************************
  // phase detection
  // ************************************************************
  mss_phase_det u_phase_det (
    .clock      (clock),
    .rst_n      (rst_n),
    .ce         (ce),
    // pins read while enable is low
    .sampleEn   (!enable),
    .capture    (state_ff == ST_DETECT && nxt_state == ST_RAMPBOOT),
    .clear      (!enable),
    .tiedHigh   (phaseIn[MAX_PHASES-1:1]),
    .phaseCount (detCount),
    .activeMask (activeMask)
  );

  // ************************************************************
  // phase clock: one tick per master cycle, rotating over active phases
  // ************************************************************
  // divide by active phase count
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      tickIdx_ff   <= '0;
      phaseTick_ff <= '0;
    end else if (ce) begin
      if (state_ff == ST_IDLE || state_ff == ST_DELAY || state_ff == ST_DETECT) begin
        tickIdx_ff   <= '0;
        phaseTick_ff <= '0;
      end else begin
        phaseTick_ff             <= '0;
        phaseTick_ff[tickIdx_ff] <= 1'b1;
        if (tickIdx_ff >= detCount - PH_CNT_W'(1)) begin
          tickIdx_ff <= '0;
        end else begin
          tickIdx_ff <= tickIdx_ff + PH_CNT_W'(1);
        end
      end
    end
  end

  // ************************************************************
  // phase output pins
  // ************************************************************
  genvar g;
  generate
    for (g = 0; g < MAX_PHASES; g++) begin : g_phase
      always_ff @(posedge clock) begin
        if (!rst_n) begin
          phaseOut_ff[g] <= 1'b0;
          phaseOe_ff[g]  <= (g == 0);
        end else if (ce) begin
          if (state_ff == ST_IDLE || state_ff == ST_DELAY || state_ff == ST_DETECT) begin
            phaseOut_ff[g] <= 1'b0;
            phaseOe_ff[g]  <= (g == 0);
          end else begin
            phaseOut_ff[g] <= activeMask[g] && pwmReq[g];
            phaseOe_ff[g]  <= activeMask[g];
          end
        end
      end
    end
  endgenerate

  assign cmdRdData  = cmdRdData_ff;
  assign phaseOut   = phaseOut_ff;
  assign phaseOe    = phaseOe_ff;
  assign phaseTick  = phaseTick_ff;
  assign refCode    = refCode_ff;
  assign powerGood  = powerGood_ff;
  assign seqState   = state_ff;
  assign phaseCount = detCount;

endmodule

//--- core/mss_pkg.sv
// constants shared by the start-up sequencer and its phase detector
// assumes a 20 MHz core clock that also serves as the master clock
package mss_pkg;

  // ************************************************************
  // clock and timing
  // ************************************************************
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned MS_PER_S        = 1000;
  localparam int unsigned CYC_PER_MS      = CLK_HZ / MS_PER_S;
  localparam int unsigned PG_MASK_US      = 100;
  localparam int unsigned PG_MASK_CYC     = (CLK_HZ / 1_000_000) * PG_MASK_US;
  localparam int unsigned DETECT_CYC      = 8;

  // ************************************************************
  // phases
  // ************************************************************
  localparam int unsigned MAX_PHASES      = 6;
  localparam int unsigned PH_CNT_W        = 3;

  // ************************************************************
  // reference in 6.25 mV steps
  // ************************************************************
  localparam int unsigned REF_W           = 9;
  localparam logic [8:0]  BOOT_STEPS      = 9'h0_0B0;  // 1.1 V / 6.25 mV = 176
  localparam int unsigned STEP_PER_TENTH  = 16;        // 0.1 V over 6.25 mV

  // ************************************************************
  // command codes and fields
  // ************************************************************
  localparam logic [7:0]  CMD_DELAY_CFG   = 8'h0_0D3;
  localparam logic [7:0]  CMD_STATUS      = 8'h0_0D4;
  localparam logic [7:0]  CMD_SS_RATE     = 8'h0_0D5;
  localparam int unsigned SS_RATE_LSB     = 0;
  localparam int unsigned SS_RATE_MSB     = 2;
  localparam logic [7:0]  SS_RATE_RST     = 8'h0_002;
  localparam logic [7:0]  DELAY_RST       = 8'h0_002;  // milliseconds
  localparam logic [7:0]  RD_UNMAPPED     = 8'h0_000;
  localparam logic [2:0]  SS_SLOW_CODE    = 3'h1;
  localparam logic [4:0]  SS_SLOW_TENTHS  = 5'h0_3;

  // ************************************************************
  // sequencer states, one-hot
  // ************************************************************
  typedef enum logic [8:0] {
    ST_IDLE     = 9'b0_0000_0001,
    ST_DELAY    = 9'b0_0000_0010,
    ST_DETECT   = 9'b0_0000_0100,
    ST_RAMPBOOT = 9'b0_0000_1000,
    ST_HOLD     = 9'b0_0001_0000,
    ST_RAMPTGT  = 9'b0_0010_0000,
    ST_MASK     = 9'b0_0100_0000,
    ST_BLANK    = 9'b0_1000_0000,
    ST_GOOD     = 9'b1_0000_0000
  } mss_state_e;

endpackage

//--- core/mss_phase_det.sv
// phase-count detector: reads the tie-high state of phase pins 2 to 6
// assumes pin levels arrive already compared against the 3 V threshold
`timescale 1ns/1ps
module mss_phase_det
  import mss_pkg::*;
(
  input  wire logic                   clock,        // master clock
  input  wire logic                   rst_n,        // sync reset, active low
  input  wire logic                   ce,           // clock enable
  input  wire logic                   sampleEn,     // sample pins this cycle
  input  wire logic                   capture,      // latch the result
  input  wire logic                   clear,        // drop the latched result
  input  wire logic [MAX_PHASES-1:1]  tiedHigh,     // pins 2..6 above threshold
  output logic      [PH_CNT_W-1:0]    phaseCount,   // latched active phases
  output logic      [MAX_PHASES-1:0]  activeMask    // latched active pins
);

  logic [MAX_PHASES-1:1] sample_ff;
  logic [PH_CNT_W-1:0]   phaseCount_ff;
  logic [MAX_PHASES-1:0] activeMask_ff;
  logic [PH_CNT_W-1:0]   nxt_count;
  logic [MAX_PHASES-1:0] nxt_mask;

  // ************************************************************
  // sampling
  // ************************************************************
  // tie-high means unused
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sample_ff <= '0;
    end else if (ce && sampleEn) begin
      sample_ff <= tiedHigh;
    end
  end

  // ************************************************************
  // count: phase 1 always used, then contiguous untied pins
  // ************************************************************
  // count from pin state
  always_comb begin
    nxt_count = PH_CNT_W'(1);
    nxt_mask  = '0;
    nxt_mask[0] = 1'b1;
    for (int i = 1; i < MAX_PHASES; i++) begin
      if (!sample_ff[i] && nxt_count == PH_CNT_W'(i)) begin
        nxt_count   = PH_CNT_W'(i + 1);
        nxt_mask[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phaseCount_ff <= PH_CNT_W'(MAX_PHASES);
      activeMask_ff <= '1;
    end else if (ce) begin
      if (clear) begin
        phaseCount_ff <= PH_CNT_W'(MAX_PHASES);
        activeMask_ff <= '1;
      end else if (capture) begin
        phaseCount_ff <= nxt_count;
        activeMask_ff <= nxt_mask;
      end
    end
  end

  assign phaseCount = phaseCount_ff;
  assign activeMask = activeMask_ff;

endmodule

//--- verif/mss_seq_props.sv
// checker for the start-up sequencer: stage timing, blanking, ramps, phase pins
// assumes ce high once start-up runs and a masking length of five cycles from the bench
`timescale 1ns/1ps
module mss_seq_props
  import mss_pkg::*;
#(
  parameter int unsigned CYC_MS   = CYC_PER_MS,  // cycles per millisecond
  parameter int unsigned MASK_CYC = PG_MASK_CYC  // masking cycles
) (
  input wire logic       clock,          // master clock
  input wire logic       rst_n,          // reset, active low
  input wire logic       ce,             // clock enable
  input wire logic       enable,         // regulator enable
  input wire logic       supplyLockout,  // supply lockout
  input wire logic [7:0] voltageCodeIn,  // target code
  input wire logic       vcodeChange,    // code change
  input wire logic [5:0] pwmReq,         // phase demand
  input wire logic [5:0] phaseIn,        // pin levels
  input wire logic       cmdWr,          // write strobe
  input wire logic [7:0] cmdCode,        // command code
  input wire logic [7:0] cmdWrData,      // write data
  input wire logic       cmdRd,          // read strobe
  input wire logic [7:0] cmdRdData,      // read data
  input wire logic [5:0] phaseOut,       // phase levels
  input wire logic [5:0] phaseOe,        // phase enables
  input wire logic [5:0] phaseTick,      // phase starts
  input wire logic [8:0] refCode,        // reference
  input wire logic       powerGood,      // power good
  input wire logic [8:0] seqState,       // state
  input wire logic [2:0] phaseCount      // phase count
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // ********************
  // properties
  // ********************
  chk_idle_force: assert property (
    ce && (!enable || supplyLockout) |=> seqState == ST_IDLE) else $error("idle not forced");
  chk_start_delay: assert property (
    ce && seqState == ST_IDLE && enable && !supplyLockout |=> seqState == ST_DELAY)
    else $error("delay not started");
  chk_detect_len: assert property (
    $rose(seqState == ST_DETECT) |-> (seqState == ST_DETECT)[*8] ##1 seqState == ST_RAMPBOOT)
    else $error("detect length wrong");
  chk_detect_blank: assert property (
    seqState == ST_DETECT |-> phaseOut == 6'h00 && phaseOe == 6'h01)
    else $error("phases not blanked");
  chk_boot_step: assert property (
    seqState == ST_RAMPBOOT |=> refCode == $past(refCode) || refCode == $past(refCode) + 9'h001)
    else $error("boot step wrong");
  chk_boot_level: assert property (
    seqState == ST_HOLD |-> refCode == BOOT_STEPS) else $error("hold not at boot level");
  chk_mask_len: assert property (
    $rose(seqState == ST_MASK) |-> (seqState == ST_MASK)[*5] ##1 seqState != ST_MASK)
    else $error("mask length wrong");
  chk_oe_mask: assert property (
    seqState == ST_GOOD |-> phaseOe == 6'((7'h01 << phaseCount) - 7'h01))
    else $error("enables not from count");
  chk_out_follow: assert property (
    seqState == ST_GOOD && $past(seqState) == ST_GOOD |-> phaseOut == ($past(pwmReq) & phaseOe))
    else $error("phase level wrong");
  chk_count_hold: assert property (
    enable && $past(enable) && $past(seqState) != ST_DETECT |-> $stable(phaseCount))
    else $error("count moved");
endmodule

bind mss_sequencer mss_seq_props #(.CYC_MS(CYC_MS), .MASK_CYC(MASK_CYC)) i_props (
  .clock(clock), .rst_n(rst_n), .ce(ce), .enable(enable), .supplyLockout(supplyLockout),
  .voltageCodeIn(voltageCodeIn), .vcodeChange(vcodeChange), .pwmReq(pwmReq),
  .phaseIn(phaseIn), .cmdWr(cmdWr), .cmdCode(cmdCode), .cmdWrData(cmdWrData), .cmdRd(cmdRd),
  .cmdRdData(cmdRdData), .phaseOut(phaseOut), .phaseOe(phaseOe), .phaseTick(phaseTick),
  .refCode(refCode), .powerGood(powerGood), .seqState(seqState), .phaseCount(phaseCount));

//--- verif/mss_board.sv
// board and processor model: tied-high phase pins and a settling voltage code
// assumes hold and idle stage flags come from the sequencer state
`timescale 1ns/1ps
module mss_board (
  input  wire logic       clock,         // master clock
  input  wire logic [2:0] tieCount,      // phases left untied
  input  wire logic [5:0] phaseOut,      // phase levels
  input  wire logic [5:0] phaseOe,       // phase enables
  input  wire logic       holdStage,     // boot hold running
  input  wire logic       idleStage,     // sequencer idle
  input  wire logic [7:0] target,        // settled code
  input  wire logic [4:0] lag,           // settling delay
  output logic      [5:0] phaseIn,       // pin above threshold
  output logic      [7:0] voltageCodeIn  // processor code
);
  logic [4:0] lagCnt  = 5'd0;
  logic       settled = 1'b0;
  initial voltageCodeIn = 8'h00;
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      phaseIn[i] = (i >= tieCount) ? 1'b1 : (phaseOe[i] & phaseOut[i]);
    end
  end
  // code wanders until settled in hold
  always @(posedge clock) begin
    if (idleStage) begin
      settled <= 1'b0;
      lagCnt  <= 5'd0;
    end else if (holdStage && !settled) begin
      lagCnt  <= lagCnt + 5'd1;
      settled <= (lagCnt == lag);
    end
    voltageCodeIn <= (settled || (holdStage && lagCnt == lag)) ? target : ~voltageCodeIn;
  end
endmodule

//--- verif/multiphase_startup_sequencer_test.sv
// self-checking bench for the start-up sequencer: registers, start-up runs, abort
// assumes the board model and the bound checker are compiled first
`timescale 1ns/1ps
module multiphase_startup_sequencer_test;
  import mss_pkg::*;
  localparam int CMS = 400;
  logic       clock = 1'b0, rst_n = 1'b0, enable = 1'b0, lockout = 1'b1;
  logic       vcodeChange = 1'b0, cmdWr = 1'b0, cmdRd = 1'b0, ce = 1'b1;
  logic [7:0] cmdCode = 8'h00, cmdWrData = 8'h00, tgt = 8'hB0, cmdRdData, vcode;
  logic [5:0] pwmReq = 6'h00, phaseIn, phaseOut, phaseOe, phaseTick, prevReq;
  logic [2:0] nPh = 3'd6, phaseCount;
  logic [4:0] lag = 5'd0;
  logic [8:0] refCode, seqState, prevSt;
  logic       powerGood, pgPrev, rdPend;
  logic [7:0] expRd[$];
  logic [8:0] expFin[$];
  int         expLen[$];
  int         err_count = 0, num_checks = 0, runLen = 0, tickGap = 0, wt;
  wire  [5:0] expMask = 6'((7'h01 << nPh) - 7'h01);

  always #25 clock = ~clock;
  always @(posedge clock) pwmReq <= 6'($urandom);

  mss_sequencer #(.CYC_MS(CMS), .MASK_CYC(5)) i_dut (
    .clock(clock), .rst_n(rst_n), .ce(ce), .enable(enable), .supplyLockout(lockout),
    .voltageCodeIn(vcode), .vcodeChange(vcodeChange), .pwmReq(pwmReq), .phaseIn(phaseIn),
    .cmdWr(cmdWr), .cmdCode(cmdCode), .cmdWrData(cmdWrData), .cmdRd(cmdRd),
    .cmdRdData(cmdRdData), .phaseOut(phaseOut), .phaseOe(phaseOe), .phaseTick(phaseTick),
    .refCode(refCode), .powerGood(powerGood), .seqState(seqState), .phaseCount(phaseCount));
  mss_board i_board (.clock(clock), .tieCount(nPh), .phaseOut(phaseOut), .phaseOe(phaseOe),
    .holdStage(seqState == ST_HOLD), .idleStage(seqState == ST_IDLE), .target(tgt),
    .lag(lag), .phaseIn(phaseIn), .voltageCodeIn(vcode));

  task automatic check_val(string nm, logic [8:0] e, logic [8:0] g);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %s expected %0h seen %0h", nm, e, g);
    end
  endtask
  // stage lengths are counted cycles; ramps may land a cycle or two off the ideal
  task automatic check_len(string nm, int e, int g, int tol);
    num_checks++;
    if (g < e - tol || g > e + tol) begin
      err_count++;
      $display("[FAIL] %s expected %0d seen %0d", nm, e, g);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic wr(logic [7:0] c, logic [7:0] d);
    cmdWr <= 1'b1;
    cmdCode <= c;
    cmdWrData <= d;
    @(posedge clock);
    cmdWr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd(logic [7:0] c, logic [7:0] e);
    cmdRd <= 1'b1;
    cmdCode <= c;
    expRd.push_back(e);
    @(posedge clock);
    cmdRd <= 1'b0;
    @(posedge clock);
  endtask

  // one start-up; delay 2 keeps the reset settings untouched
  task automatic run(logic [2:0] rate, logic [2:0] ph, int dly, bit abort);
    int         tenths;
    logic [7:0] t;
    tenths = (rate < 3'd2) ? 3 : 2 * rate + 1;
    t = 8'($urandom_range(250, 100));
    tgt <= t;
    nPh <= ph;
    lag <= 5'($urandom);
    if (dly != 2) begin
      wr(CMD_SS_RATE, {5'h00, rate});
      wr(CMD_DELAY_CFG, 8'(dly));
    end
    rd(CMD_SS_RATE, {5'h00, rate});
    expLen.push_back(dly * CMS + 1);
    if (!abort) begin
      expLen.push_back(176 * CMS / (tenths * 16));
      expLen.push_back(dly * CMS + 1);
      expLen.push_back(dly * CMS + 1);
      expFin.push_back({1'b0, t});
      expFin.push_back({6'h00, ph});
    end
    enable <= 1'b1;
    repeat (10) @(posedge clock);
    check_val("seqState", ST_IDLE, seqState);
    lockout <= 1'b0;
    for (wt = 0; wt < 20000 && seqState !== (abort ? ST_RAMPBOOT : ST_GOOD); wt++)
      @(posedge clock);
    if (wt == 20000) begin
      err_count++;
      $display("[FAIL] seqState expected %0h seen %0h", abort ? ST_RAMPBOOT : ST_GOOD,
               seqState);
      print_verdict();
    end
    if (abort) repeat (20) @(posedge clock);
    else begin
      rd(CMD_STATUS, {1'b1, 4'h0, ph});
      vcodeChange <= 1'b1;
      @(posedge clock);
      vcodeChange <= 1'b0;
      repeat (10) @(posedge clock);
    end
    enable <= 1'b0;
    repeat (4) @(posedge clock);
    check_val("refCode", 9'h000, refCode);
    lockout <= 1'b1;
    $display("run rate %0d phases %0d abort %0d done", rate, ph, abort);
  endtask

  always @(posedge clock) begin
    prevSt <= seqState;
    prevReq <= pwmReq;
    pgPrev <= powerGood;
    rdPend <= cmdRd;
    if (rdPend) check_val("cmdRdData", {1'b0, expRd.pop_front()}, {1'b0, cmdRdData});
    if (seqState !== prevSt) begin
      if (prevSt inside {ST_DELAY, ST_RAMPBOOT, ST_HOLD, ST_BLANK} && seqState !== ST_IDLE)
        check_len("stageLen", expLen.pop_front(), runLen, prevSt == ST_RAMPBOOT ? 2 : 0);
      runLen = 1;
    end else runLen++;
    if (powerGood && !pgPrev && prevSt === ST_BLANK) begin
      check_val("refCode", expFin.pop_front(), refCode);
      check_val("phaseCount", expFin.pop_front(), {6'h00, phaseCount});
    end
    if (seqState === ST_GOOD) begin
      check_val("phaseOe", {3'h0, expMask}, {3'h0, phaseOe});
      check_val("phaseOut", {3'h0, prevReq & expMask}, {3'h0, phaseOut});
    end
    if (phaseTick[0]) begin
      if (seqState === ST_GOOD) check_val("tickGap", {6'h00, nPh}, 9'(tickGap));
      tickGap = 1;
    end else tickGap++;
  end

  initial begin
    wt = $urandom(32'h4e39_a1e1);
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    rd(CMD_SS_RATE, SS_RATE_RST);
    rd(CMD_DELAY_CFG, DELAY_RST);
    wr(8'h77, 8'h5A);
    rd(8'h77, RD_UNMAPPED);
    // clock enable low: a rate write must not land
    ce <= 1'b0;
    wr(CMD_SS_RATE, 8'h07);
    ce <= 1'b1;
    rd(CMD_SS_RATE, SS_RATE_RST);
    $display("register test done");
    run(3'd2, 3'd6, 2, 1'b0);
    for (int c = 0; c < 8; c++) run(3'(c), 3'(1 + c % 6), 1, 1'b0);
    run(3'd7, 3'd4, 1, 1'b1);
    print_verdict();
  end
endmodule
